/* hw/bypass_unit.v */
// bypass unit: keylock bypass interlocks for one division
`timescale 1ns/1ps
`include "trip_division_map.vh"

module bypass_unit
(
  input  wire             aclk,
  input  wire             aresetn,
  input  wire [3:0]       key_sensor_byp,
  input  wire             key_msl_byp,
  input  wire             msl_byp_permit,
  input  wire             key_tdu_byp,
  output reg  [3:0]       chan_byp,
  output reg  [3:0]       msl_byp,
  output reg              tdu_byp
);

  reg [2:0] key_count;
  integer   i;

  // count keyed channels; more than one key is refused so two channels never drop out
  always @*
  begin
    key_count = 3'h0;
    for (i = 0; i < `NCH; i = i + 1)
      key_count = key_count + {2'h0, key_sensor_byp[i]};
  end

  // bypasses are active high and start only from their own keylock [RULE2] [RULE5]
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      chan_byp <= 4'h0;
      msl_byp  <= 4'h0;
      tdu_byp  <= 1'h0;
    end
    else
    begin
      chan_byp <= (key_count == 3'h1) ? key_sensor_byp : 4'h0; // [RULE6]
      msl_byp  <= {4{key_msl_byp & msl_byp_permit}};           // [RULE6]
      tdu_byp  <= key_tdu_byp;                                  // [RULE7]
    end
  end

endmodule // bypass_unit

/* hw/trip_division.v */
// trip division top: input sync, voting decision unit, manual path, bus slave
// Operation
// [RULE1] any lost power or input drives the division to its tripped state
// [RULE2] trip signals are active low; bypass and permissive signals active high
// [RULE3] each variable trips on two of four channels; one failure neither blocks nor trips
// [RULE4] each channel comparator sends one trip bit per variable to every division
// [RULE5] three bypasses, each started only by its own keylock switch
// [RULE6] bypass unit gives per-channel sensor and steam line bypass to decision unit
// [RULE7] decision unit bypass goes to the output unit, not the decision unit
// [RULE8] automatic trip comes from mode, channel trips, division trips and bypasses
// [RULE9] decision unit takes four channels, neutron monitor divisions and own switches
// [RULE10] output unit trips, seals in, resets, tests and drives own actuators
// [RULE11] the reset permissive arrives from scram logic circuit equipment
// [RULE12] manual scram path shares no logic with the automatic path
// [RULE13] sealed trip holds until manual reset while reset permissive is high
// [RULE14] active decision unit bypass stops that unit from tripping the division
`timescale 1ns/1ps
`include "trip_division_map.vh"

module trip_division
(
  input  wire                  aclk,
  input  wire                  aresetn,
  input  wire [`ADDR_W-1:0]    awaddr,
  input  wire                  awvalid,
  output reg                   awready,
  input  wire [31:0]           wdata,
  input  wire [3:0]            wstrb,
  input  wire                  wvalid,
  output reg                   wready,
  output reg  [1:0]            bresp,
  output reg                   bvalid,
  input  wire                  bready,
  input  wire [`ADDR_W-1:0]    araddr,
  input  wire                  arvalid,
  output reg                   arready,
  output reg  [31:0]           rdata,
  output reg  [1:0]            rresp,
  output reg                   rvalid,
  input  wire                  rready,
  input  wire [31:0]           ch_trip_n,
  input  wire [3:0]            nm_trip_n,
  input  wire [3:0]            key_sensor_byp,
  input  wire                  key_msl_byp,
  input  wire                  msl_byp_permit,
  input  wire                  key_tdu_byp,
  input  wire                  test_trip_n,
  input  wire                  man_reset,
  input  wire                  reset_permit,
  input  wire                  manual_scram_n,
  output wire                  act_trip_n,
  output wire                  dump_trip_n,
  output reg                   manual_scram_out_n
);
  // ************************************************************
  // functions
  // ************************************************************
  // two-out-of-four on the channels left in service
  function vote2;
    input [3:0] trip;
    input [3:0] byp;
    reg   [3:0] a;
    begin
      a     = trip & ~byp;
      vote2 = (a[0] & a[1]) | (a[0] & a[2]) | (a[0] & a[3])
            | (a[1] & a[2]) | (a[1] & a[3]) | (a[2] & a[3]);
    end
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  wire [`IN_W-1:0] pin_raw;
  reg  [`IN_W-1:0] meta_reg;
  reg  [`IN_W-1:0] pin_reg;
  assign pin_raw = {manual_scram_n, reset_permit, man_reset, test_trip_n,
                    key_tdu_byp, msl_byp_permit, key_msl_byp, key_sensor_byp,
                    nm_trip_n, ch_trip_n};
  // reset value zero reads as trip for low inputs and no bypass for high ones
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg <= {`IN_W{1'h0}};                 // [RULE1]
      pin_reg  <= {`IN_W{1'h0}};
    end
    else
    begin
      meta_reg <= pin_raw;
      pin_reg  <= meta_reg;
    end
  end
  wire [31:0] s_ch_trip_n   = pin_reg[31:0];     // channel-major, one bit per variable [RULE4]
  wire [3:0]  s_nm_trip_n   = pin_reg[35:32];
  wire [3:0]  s_key_sensor  = pin_reg[39:36];
  wire        s_key_msl     = pin_reg[40];
  wire        s_msl_permit  = pin_reg[41];
  wire        s_key_tdu     = pin_reg[42];
  wire        s_test_trip_n = pin_reg[43];
  wire        s_man_reset   = pin_reg[44];
  wire        s_permit      = pin_reg[45];
  wire        s_manual_n    = pin_reg[46];

  // ************************************************************
  // manual scram path
  // ************************************************************
  // kept apart from every automatic signal so one path cannot mask the other
  always @(posedge aclk)
  begin
    if (!aresetn)
      manual_scram_out_n <= 1'h0;
    else
      manual_scram_out_n <= s_manual_n;          // [RULE12]
  end

  // ************************************************************
  // bypass unit
  // ************************************************************
  wire [3:0] chan_byp;
  wire [3:0] msl_byp;
  wire       tdu_byp;
  bypass_unit u_bypass
  (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .key_sensor_byp (s_key_sensor),
    .key_msl_byp    (s_key_msl),
    .msl_byp_permit (s_msl_permit),
    .key_tdu_byp    (s_key_tdu),
    .chan_byp       (chan_byp),
    .msl_byp        (msl_byp),
    .tdu_byp        (tdu_byp)
  );

  // ************************************************************
  // trip decision unit
  // ************************************************************
  reg  [1:0]       mode_reg;
  reg              test_reg;
  wire [`NVAR-1:0] var_vote;
  reg  [`NVAR-1:0] var_trip_reg;
  reg              nm_trip_reg;
  reg              tdu_trip_n_reg;
  // only run mode arms the steam line isolation variable
  wire [`NVAR-1:0] armed = (mode_reg == `MODE_RUN) ? `MASK_RUN : `MASK_NOT_RUN;
  // per-variable vote, steam line variable also drops specially bypassed channels
  genvar v;
  generate
    for (v = 0; v < `NVAR; v = v + 1)
    begin : g_var
      wire [3:0] trip_v = ~{s_ch_trip_n[3*`NVAR+v], s_ch_trip_n[2*`NVAR+v],
                            s_ch_trip_n[`NVAR+v],   s_ch_trip_n[v]};
      wire [3:0] byp_v  = chan_byp | ((v == `MSL_VAR) ? msl_byp : 4'h0); // [RULE6]
      assign var_vote[v] = vote2(trip_v, byp_v);                         // [RULE3]
    end
  endgenerate
  // neutron monitor divisions are voted the same way but never sensor-bypassed
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      var_trip_reg   <= {`NVAR{1'h1}};
      nm_trip_reg    <= 1'h1;
      tdu_trip_n_reg <= 1'h0;
    end
    else
    begin
      var_trip_reg   <= var_vote;
      nm_trip_reg    <= vote2(~s_nm_trip_n, 4'h0);                      // [RULE9] [RULE3]
      tdu_trip_n_reg <= ~((|(var_trip_reg & armed)) | nm_trip_reg);     // [RULE8] [RULE2]
    end
  end

  // ************************************************************
  // trip output unit
  // ************************************************************
  wire sealed;
  wire test_n = s_test_trip_n & ~test_reg;      // switch or software trip test
  trip_output_unit u_output
  (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .tdu_trip_n   (tdu_trip_n_reg),
    .tdu_byp      (tdu_byp),                     // [RULE7] [RULE14]
    .test_trip_n  (test_n),
    .man_reset    (s_man_reset),
    .reset_permit (s_permit),
    .sealed       (sealed),
    .act_trip_n   (act_trip_n),
    .dump_trip_n  (dump_trip_n)
  );
  // first-out capture: which variables stood tripped when the seal was set
  reg              sealed_d_reg;
  reg [`NVAR-1:0]  first_reg;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sealed_d_reg <= 1'h1;
      first_reg    <= {`NVAR{1'h0}};
    end
    else
    begin
      sealed_d_reg <= sealed;
      if (sealed & ~sealed_d_reg)
        first_reg <= var_trip_reg;
    end
  end

  // ************************************************************
  // register read mux
  // ************************************************************
  reg [31:0] rd_data;
  reg        rd_err;
  always @*
  begin
    rd_data = 32'h0;
    rd_err  = 1'h0;
    case (araddr)
      `OFF_CTRL:
      begin
        rd_data[`CTRL_MODE_HI:`CTRL_MODE_LO] = mode_reg;
        rd_data[`CTRL_TEST]                  = test_reg;
      end
      `OFF_STATUS:
      begin
        rd_data[`ST_SEALED]                  = sealed;
        rd_data[`ST_TDU_TRIP]                = ~tdu_trip_n_reg;
        rd_data[`ST_TDU_BYP]                 = tdu_byp;
        rd_data[`ST_MANUAL]                  = ~manual_scram_out_n;
        rd_data[`ST_CH_BYP_HI:`ST_CH_BYP_LO] = chan_byp;
        rd_data[`ST_MSL_BYP]                 = msl_byp[0];
        rd_data[`ST_PERMIT]                  = s_permit;
        rd_data[`ST_NM_TRIP]                 = nm_trip_reg;
      end
      `OFF_VAR_TRIP:  rd_data[`NVAR-1:0] = var_trip_reg;
      `OFF_FIRST_OUT: rd_data[`NVAR-1:0] = first_reg;
      default:        rd_err = 1'h1;
    endcase
  end

  // ************************************************************
  // axi4-lite write channel
  // ************************************************************
  reg               aw_got;
  reg               w_got;
  reg [`ADDR_W-1:0] waddr_q;
  reg [31:0]        wdata_q;
  reg [3:0]         wstrb_q;
  // address and data are taken in either order; response one edge after both
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready  <= 1'h1;
      wready   <= 1'h1;
      bvalid   <= 1'h0;
      bresp    <= `RESP_OKAY;
      aw_got   <= 1'h0;
      w_got    <= 1'h0;
      waddr_q  <= {`ADDR_W{1'h0}};
      wdata_q  <= 32'h0;
      wstrb_q  <= 4'h0;
      mode_reg <= `CTRL_MODE_RST;
      test_reg <= `CTRL_TEST_RST;
    end
    else
    begin
      if (awvalid & awready)
      begin
        aw_got  <= 1'h1;
        waddr_q <= awaddr;
        awready <= 1'h0;
      end
      if (wvalid & wready)
      begin
        w_got   <= 1'h1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        wready  <= 1'h0;
      end
      if (aw_got & w_got & ~bvalid)
      begin
        aw_got <= 1'h0;
        w_got  <= 1'h0;
        bvalid <= 1'h1;
        bresp  <= `RESP_OKAY;
        case (waddr_q)
          `OFF_CTRL:
          begin
            if (wstrb_q[0])
            begin
              mode_reg <= wdata_q[`CTRL_MODE_HI:`CTRL_MODE_LO];
              test_reg <= wdata_q[`CTRL_TEST];
            end
          end
          `OFF_STATUS, `OFF_VAR_TRIP, `OFF_FIRST_OUT: bresp <= `RESP_OKAY;
          default: bresp <= `RESP_SLVERR;
        endcase
      end
      if (bvalid & bready)
      begin
        bvalid  <= 1'h0;
        awready <= 1'h1;
        wready  <= 1'h1;
      end
    end
  end

  // ************************************************************
  // axi4-lite read channel
  // ************************************************************
  // data sampled at the address edge, so a read is a snapshot of one cycle
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'h1;
      rvalid  <= 1'h0;
      rdata   <= 32'h0;
      rresp   <= `RESP_OKAY;
    end
    else
    begin
      if (arvalid & arready)
      begin
        arready <= 1'h0;
        rvalid  <= 1'h1;
        rdata   <= rd_data;
        rresp   <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
      end
      else if (rvalid & rready)
      begin
        rvalid  <= 1'h0;
        arready <= 1'h1;
      end
    end
  end
endmodule // trip_division

/* hw/trip_output_unit.v */
// trip output unit: division trip, seal-in, reset and trip test
`timescale 1ns/1ps
`include "trip_division_map.vh"

module trip_output_unit
(
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             tdu_trip_n,
  input  wire             tdu_byp,
  input  wire             test_trip_n,
  input  wire             man_reset,
  input  wire             reset_permit,
  output reg              sealed,
  output reg              act_trip_n,
  output reg              dump_trip_n
);

  reg trip_req;
  reg sealed_next;

  // bypassed decision unit cannot trip; test trip always can [RULE14] [RULE10]
  always @*
  begin
    trip_req    = (~tdu_trip_n & ~tdu_byp) | ~test_trip_n;
    sealed_next = sealed;
    if (trip_req)
      sealed_next = 1'h1;                      // set wins over reset [RULE10]
    else if (man_reset & reset_permit)
      sealed_next = 1'h0;                      // [RULE13] [RULE11]
  end

  // power-up comes out sealed, so the actuators stay tripped until reset [RULE1]
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sealed      <= 1'h1;
      act_trip_n  <= 1'h0;
      dump_trip_n <= 1'h0;
    end
    else
    begin
      sealed      <= sealed_next;
      act_trip_n  <= ~sealed_next;             // active low to actuators [RULE2]
      dump_trip_n <= ~sealed_next;
    end
  end

endmodule // trip_output_unit

/* shared/trip_division_map.vh */
// constants of the trip division: offsets, fields, reset values, codes
`ifndef TRIP_DIVISION_MAP_VH
`define TRIP_DIVISION_MAP_VH

// ************************************************************
// sizes
// ************************************************************
`define NCH            4
`define NVAR           8
`define MSL_VAR        3
`define IN_W           47
`define ADDR_W         8

// ************************************************************
// register byte offsets
// ************************************************************
`define OFF_CTRL       8'h00
`define OFF_STATUS     8'h04
`define OFF_VAR_TRIP   8'h08
`define OFF_FIRST_OUT  8'h0C

// ************************************************************
// control fields and reset values
// ************************************************************
`define CTRL_MODE_LO   0
`define CTRL_MODE_HI   1
`define CTRL_TEST      4
`define CTRL_MODE_RST  2'h3
`define CTRL_TEST_RST  1'h0

// ************************************************************
// status fields
// ************************************************************
`define ST_SEALED      0
`define ST_TDU_TRIP    1
`define ST_TDU_BYP     2
`define ST_MANUAL      3
`define ST_CH_BYP_LO   4
`define ST_CH_BYP_HI   7
`define ST_MSL_BYP     8
`define ST_PERMIT      9
`define ST_NM_TRIP     10

// ************************************************************
// operating modes and armed-variable masks
// ************************************************************
`define MODE_SHUTDOWN  2'h0
`define MODE_REFUEL    2'h1
`define MODE_STARTUP   2'h2
`define MODE_RUN       2'h3
`define MASK_NOT_RUN   8'hF7
`define MASK_RUN       8'hFF

// ************************************************************
// bus responses
// ************************************************************
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

/* verif/sensor_channels.sv */
// model of the channel comparators, neutron monitors and permissive source
`timescale 1ns/1ps

module sensor_channels
(
  input  wire        aclk,
  input  wire [31:0] trip_cmd,
  input  wire [3:0]  nm_cmd,
  input  wire        permit_cmd,
  output reg  [31:0] ch_trip_n,
  output reg  [3:0]  nm_trip_n,
  output reg         reset_permit
);
  // outputs change only after an edge, like the real comparator links
  always @(posedge aclk)
  begin
    ch_trip_n    <= ~trip_cmd;  // one low bit per tripped variable
    nm_trip_n    <= ~nm_cmd;
    reset_permit <= permit_cmd;
  end
endmodule // sensor_channels

/* verif/testbench.sv */
// self-checking bench of the trip division
`timescale 1ns/1ps
`include "trip_division_map.vh"

module testbench;
  reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  reg  [7:0]  awaddr, araddr, seed;
  reg  [31:0] wdata, trip_cmd;
  reg  [3:0]  wstrb, nm_cmd, key_sensor_byp;
  reg         key_msl_byp, msl_byp_permit, key_tdu_byp, test_trip_n;
  reg         man_reset, permit_cmd, manual_scram_n;
  wire        awready, wready, bvalid, arready, rvalid, reset_permit;
  wire        act_trip_n, dump_trip_n, manual_scram_out_n;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata, ch_trip_n;
  wire [3:0]  nm_trip_n;
  reg  [65:0] rq[$];
  reg  [65:0] e;
  reg  [1:0]  bq[$];
  integer     errors, num_checks, cyc, i;

  trip_division i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ch_trip_n(ch_trip_n), .nm_trip_n(nm_trip_n), .key_sensor_byp(key_sensor_byp),
    .key_msl_byp(key_msl_byp), .msl_byp_permit(msl_byp_permit), .key_tdu_byp(key_tdu_byp),
    .test_trip_n(test_trip_n), .man_reset(man_reset), .reset_permit(reset_permit),
    .manual_scram_n(manual_scram_n), .act_trip_n(act_trip_n), .dump_trip_n(dump_trip_n),
    .manual_scram_out_n(manual_scram_out_n));
  sensor_channels i_far (.aclk(aclk), .trip_cmd(trip_cmd), .nm_cmd(nm_cmd),
    .permit_cmd(permit_cmd), .ch_trip_n(ch_trip_n), .nm_trip_n(nm_trip_n),
    .reset_permit(reset_permit));

  // ************************************************************
  // clock, timeout, helpers
  // ************************************************************
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // the whole run needs a few hundred cycles
  always @(posedge aclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      bad("timeout");
      summarize;
    end
  end
  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task bad(input string m);
    errors = errors + 1;
    $display("unexpected at %0t: %0s", $time, m);
  endtask
  task step(input integer n);
    repeat (n) @(posedge aclk);
  endtask
  task chk(input reg exp);
    step(8);
    num_checks = num_checks + 1;
    if (act_trip_n !== exp) bad("actuator trip level");
  endtask
  // seal release needs the permissive and a quiet trip path
  task clear_seal;
    trip_cmd <= 32'h0;
    permit_cmd <= 1'b1;
    man_reset <= 1'b1;
    step(8);
    man_reset <= 1'b0;
    step(2);
  endtask
  // ************************************************************
  // bus master: expected answers go to queues, monitor compares
  // ************************************************************
  task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    step(1);
    bq.push_back(r);
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
  endtask
  task rd(input [7:0] a, input [31:0] d, input [31:0] m, input [1:0] r);
    step(1);
    rq.push_back({r, d, m});
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
  endtask
  // oldest note is taken off as each answer is seen
  always @(posedge aclk)
  begin
    if (rvalid && rready && rq.size() > 0)
    begin
      e = rq.pop_front();
      num_checks = num_checks + 1;
      if (rresp !== e[65:64] || (rdata & e[31:0]) !== e[63:32]) bad("read answer");
    end
    if (bvalid && bready && bq.size() > 0)
    begin
      num_checks = num_checks + 1;
      if (bresp !== bq.pop_front()) bad("write response");
    end
  end
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  initial
  begin
    errors = 0; num_checks = 0; cyc = 0; seed = 8'h53;
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
    trip_cmd = 32'h0; nm_cmd = 4'h0; key_sensor_byp = 4'h0; key_msl_byp = 1'b0;
    msl_byp_permit = 1'b0; key_tdu_byp = 1'b0; test_trip_n = 1'b1; man_reset = 1'b0;
    permit_cmd = 1'b0; manual_scram_n = 1'b1;
    step(16);
    aresetn <= 1'b1;
    chk(1'b0);
    man_reset <= 1'b1;
    chk(1'b0);
    clear_seal;
    chk(1'b1);
    rd(`OFF_CTRL, 32'h3, 32'h13, `RESP_OKAY);
    $display("test seal done");
    // random single failures never trip, a second channel does
    for (i = 0; i < 6; i = i + 1)
    begin
      seed = lfsr(seed);
      trip_cmd <= 32'h1 << {seed[1:0], seed[4:2]};
      chk(1'b1);
    end
    // upper seed bits pick var 7 here, so the checker's vote sees the pair too
    trip_cmd <= (32'h1 << {seed[1:0], seed[7:5]}) | (32'h1 << {seed[1:0] + 2'h1, seed[7:5]});
    chk(1'b0);
    trip_cmd <= 32'h0;
    chk(1'b0);
    rd(`OFF_FIRST_OUT, 32'h1 << seed[7:5], 32'hFF, `RESP_OKAY);
    clear_seal;
    $display("test vote done");
    // steam line variable is armed only in run mode
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(`OFF_CTRL, i, `RESP_OKAY);
      rd(`OFF_CTRL, i, 32'h13, `RESP_OKAY);
      trip_cmd <= 32'h0000_0808;
      chk(i != 3);
      clear_seal;
    end
    $display("test mode done");
    key_sensor_byp <= 4'h1;
    trip_cmd <= 32'h0000_0202;
    chk(1'b1);
    rd(`OFF_STATUS, 32'h10, 32'hF0, `RESP_OKAY);
    key_sensor_byp <= 4'h3;
    chk(1'b0);
    key_sensor_byp <= 4'h0;
    clear_seal;
    key_msl_byp <= 1'b1;
    step(6);
    rd(`OFF_STATUS, 32'h0, 32'h100, `RESP_OKAY);
    msl_byp_permit <= 1'b1;
    step(6);
    rd(`OFF_STATUS, 32'h100, 32'h100, `RESP_OKAY);
    key_msl_byp <= 1'b0;
    msl_byp_permit <= 1'b0;
    key_tdu_byp <= 1'b1;
    trip_cmd <= 32'h0000_0202;
    chk(1'b1);
    test_trip_n <= 1'b0;
    chk(1'b0);
    test_trip_n <= 1'b1;
    key_tdu_byp <= 1'b0;
    clear_seal;
    // software trip test through the control register
    wr(`OFF_CTRL, 32'h13, `RESP_OKAY);
    chk(1'b0);
    rd(`OFF_CTRL, 32'h13, 32'h13, `RESP_OKAY);
    wr(`OFF_CTRL, 32'h3, `RESP_OKAY);
    clear_seal;
    $display("test bypass done");
    nm_cmd <= 4'h4;
    chk(1'b1);
    nm_cmd <= 4'h6;
    chk(1'b0);
    nm_cmd <= 4'h0;
    clear_seal;
    manual_scram_n <= 1'b0;
    chk(1'b1);
    num_checks = num_checks + 1;
    if (manual_scram_out_n !== 1'b0) bad("manual scram out");
    manual_scram_n <= 1'b1;
    $display("test manual done");
    rd(8'h10, 32'h0, 32'hFFFFFFFF, `RESP_SLVERR);
    wr(8'h10, 32'h1, `RESP_SLVERR);
    wr(`OFF_STATUS, 32'hFFFFFFFF, `RESP_OKAY);
    rd(`OFF_VAR_TRIP, 32'h0, 32'hFF, `RESP_OKAY);
    wr(`OFF_CTRL, 32'h1, `RESP_OKAY);
    aresetn <= 1'b0;
    step(3);
    aresetn <= 1'b1;
    rd(`OFF_CTRL, 32'h3, 32'h13, `RESP_OKAY);
    chk(1'b0);
    $display("test bus done");
    step(4);
    summarize;
  end
endmodule // testbench

/* verif/trip_division_props.sv */
// concurrent checks on the trip division ports
`timescale 1ns/1ps

module trip_division_props
(
  input wire        aclk,
  input wire        aresetn,
  input wire        arvalid,
  input wire        arready,
  input wire        rvalid,
  input wire        rready,
  input wire [31:0] rdata,
  input wire [31:0] ch_trip_n,
  input wire [3:0]  key_sensor_byp,
  input wire        key_tdu_byp,
  input wire        test_trip_n,
  input wire        man_reset,
  input wire        reset_permit,
  input wire        manual_scram_n,
  input wire        act_trip_n,
  input wire        dump_trip_n,
  input wire        manual_scram_out_n
);
  // ************************************************************
  // helpers
  // ************************************************************
  reg  [2:0] rcnt;
  wire       vote2;
  // cycles since reset release, saturating; keeps $past out of reset
  always @(posedge aclk)
  begin
    if (!aresetn) rcnt <= 3'h0;
    else if (rcnt != 3'h7) rcnt <= rcnt + 3'h1;
  end
  // two channels low on one always-armed variable
  function automatic logic votes(input logic [31:0] t);
    integer v;
    votes = 1'b0;
    for (v = 0; v < 8; v = v + 1)
      if (v != 3 && (!t[v] + !t[v+8] + !t[v+16] + !t[v+24]) >= 2) votes = 1'b1;
  endfunction
  assign vote2 = votes(ch_trip_n);
  // ************************************************************
  // assertions
  // ************************************************************
  chk_reset_sealed: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> !act_trip_n) else $error("not sealed after reset");
  chk_dump_equal: assert property (@(posedge aclk) disable iff (!aresetn)
    dump_trip_n == act_trip_n) else $error("dump trip differs from actuator trip");
  chk_manual_delay: assert property (@(posedge aclk) disable iff (!aresetn)
    rcnt == 3'h7 |-> manual_scram_out_n == $past(manual_scram_n, 3))
    else $error("manual scram path delay wrong");
  chk_seal_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (!man_reset) [*5] ##0 !act_trip_n |=> !act_trip_n) else $error("seal dropped without reset");
  chk_permit_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (!reset_permit) [*5] ##0 !act_trip_n |=> !act_trip_n) else $error("reset without permit");
  chk_two_vote: assert property (@(posedge aclk) disable iff (!aresetn)
    (vote2 && !key_tdu_byp && key_sensor_byp == 4'h0) [*7] |-> !act_trip_n)
    else $error("two channel vote did not trip");
  chk_tdu_block: assert property (@(posedge aclk) disable iff (!aresetn)
    (key_tdu_byp && test_trip_n) [*6] ##0 act_trip_n |=> act_trip_n)
    else $error("bypassed decision unit tripped");
  chk_test_trip: assert property (@(posedge aclk) disable iff (!aresetn)
    (!test_trip_n) [*6] |-> !act_trip_n) else $error("test trip ignored");
  chk_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready |=> rvalid ##0 !arready) else $error("read not answered");
  chk_read_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data not held");
endmodule // trip_division_props

bind trip_division trip_division_props u_props
(
  .aclk(aclk), .aresetn(aresetn), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .rready(rready), .rdata(rdata), .ch_trip_n(ch_trip_n), .key_sensor_byp(key_sensor_byp),
  .key_tdu_byp(key_tdu_byp), .test_trip_n(test_trip_n), .man_reset(man_reset),
  .reset_permit(reset_permit), .manual_scram_n(manual_scram_n), .act_trip_n(act_trip_n),
  .dump_trip_n(dump_trip_n), .manual_scram_out_n(manual_scram_out_n)
);
